// ==== design/arinc_sched_defines.svh ====
// constants for the transmit frame scheduler
`ifndef ARINC_SCHED_DEFINES_SVH
`define ARINC_SCHED_DEFINES_SVH
`define SCHED_ENTRIES        256
`define SCHED_IDX_W          8
`define SCHED_MINOR_FRAMES   16
`define SCHED_WORD_W         32
`define SCHED_DELAY_W        24
`define SCHED_PRESCALE_W     16
`define SCHED_CLK_HZ         40000000
`define SCHED_TICK_US        100
`define SCHED_TICK_CYC       ((`SCHED_CLK_HZ / 1000000) * `SCHED_TICK_US)
`define SCHED_US_CYC         (`SCHED_CLK_HZ / 1000000)
`define SCHED_LO_RATE_HZ     12500
`define SCHED_HI_RATE_HZ     100000
`define SCHED_LO_HALF_CYC    (`SCHED_CLK_HZ / (2 * `SCHED_LO_RATE_HZ))
`define SCHED_HI_HALF_CYC    (`SCHED_CLK_HZ / (2 * `SCHED_HI_RATE_HZ))
`define SCHED_GAP_BITS       4
`define SCHED_CNT_W          16
`endif

// ==== design/arinc_sched_pkg.sv ====
// types for the transmit frame scheduler
package arinc_sched_pkg;
  typedef enum logic [3:0] {
    SCAN_IDLE  = 4'b0001,
    SCAN_WAIT  = 4'b0010,
    SCAN_CHECK = 4'b0100,
    SCAN_PUSH  = 4'b1000
  } scan_state_t;
  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_BIT  = 3'b010,
    SER_GAP  = 3'b100
  } ser_state_t;
endpackage

// ==== design/word_skid_buffer.sv ====
// two-entry buffer between scheduler and serialiser
`timescale 1ns/1ps
`default_nettype none
`include "arinc_sched_defines.svh"
module word_skid_buffer
(
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [`SCHED_WORD_W-1:0] in_data_i,
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [`SCHED_WORD_W-1:0]      out_data_o
);
  logic [`SCHED_WORD_W-1:0] slot_reg [2];
  logic [`SCHED_WORD_W-1:0] slot_next [2];
  logic [1:0]               count_reg;
  logic [1:0]               count_next;
  logic                     push;
  logic                     pop;

  // head always in slot 0; shift on pop
  always_comb
  begin
    push = in_valid_i && (count_reg != 2'h2);
    pop = out_ready_i && (count_reg != 2'h0);
    slot_next[0] = slot_reg[0];
    slot_next[1] = slot_reg[1];
    count_next = count_reg;
    if (pop)
    begin
      slot_next[0] = slot_reg[1];
    end
    if (push)
    begin
      if (count_reg == 2'h0 || (pop && count_reg == 2'h1))
      begin
        slot_next[0] = in_data_i;
      end
      else
      begin
        slot_next[(pop) ? 0 : 1] = in_data_i;
      end
    end
    if (push && !pop)
    begin
      count_next = count_reg + 2'h1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      count_reg <= 2'h0;
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
    end
    else
    begin
      count_reg <= count_next;
      slot_reg[0] <= slot_next[0];
      slot_reg[1] <= slot_next[1];
    end
  end

  assign in_ready_o = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o = slot_reg[0];
endmodule
`default_nettype wire

// ==== design/arinc_serializer.sv ====
// bipolar serialiser for one 32-bit word, lsb first
`timescale 1ns/1ps
`default_nettype none
`include "arinc_sched_defines.svh"
module arinc_serializer
  import arinc_sched_pkg::*;
(
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     high_speed_i,
  input  wire logic                     word_valid_i,
  output logic                          word_ready_o,
  input  wire logic [`SCHED_WORD_W-1:0] word_i,
  output logic                          line_a_o,
  output logic                          line_b_o,
  output logic                          busy_o
);
  ser_state_t               state_reg;
  ser_state_t               state_next;
  logic [`SCHED_WORD_W-1:0] shift_reg;
  logic [`SCHED_WORD_W-1:0] shift_next;
  logic [5:0]               bit_reg;
  logic [5:0]               bit_next;
  logic [10:0]              half_reg;
  logic [10:0]              half_next;
  logic                     phase_reg;
  logic                     phase_next;
  logic                     a_reg;
  logic                     a_next;
  logic                     b_reg;
  logic                     b_next;
  logic [10:0]              half_len;

  // each bit is a high/low half then a null half (return to zero)
  always_comb
  begin
    half_len = high_speed_i ? 11'(`SCHED_HI_HALF_CYC - 1) : 11'(`SCHED_LO_HALF_CYC - 1);
    state_next = state_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    half_next = half_reg;
    phase_next = phase_reg;
    a_next = 1'b0;
    b_next = 1'b0;
    word_ready_o = 1'b0;
    case (state_reg)
      SER_IDLE:
      begin
        word_ready_o = 1'b1;
        if (word_valid_i)
        begin
          shift_next = word_i;
          bit_next = 6'h0;
          half_next = half_len;
          phase_next = 1'b0;
          state_next = SER_BIT;
          a_next = word_i[0];
          b_next = ~word_i[0];
        end
      end
      SER_BIT:
      begin
        a_next = a_reg;
        b_next = b_reg;
        if (half_reg != 11'h0)
        begin
          half_next = half_reg - 11'h1;
        end
        else if (!phase_reg)
        begin
          phase_next = 1'b1;
          half_next = half_len;
          a_next = 1'b0;
          b_next = 1'b0;
        end
        else if (bit_reg == 6'd31)
        begin
          state_next = SER_GAP;
          bit_next = 6'h0;
          half_next = half_len;
          a_next = 1'b0;
          b_next = 1'b0;
        end
        else
        begin
          shift_next = {1'b0, shift_reg[`SCHED_WORD_W-1:1]};
          bit_next = bit_reg + 6'h1;
          phase_next = 1'b0;
          half_next = half_len;
          a_next = shift_reg[1];
          b_next = ~shift_reg[1];
        end
      end
      SER_GAP:
      begin
        // inter-word null period so receivers can frame words
        if (half_reg != 11'h0)
        begin
          half_next = half_reg - 11'h1;
        end
        else if (bit_reg == 6'(2 * `SCHED_GAP_BITS - 1))
        begin
          state_next = SER_IDLE;
        end
        else
        begin
          bit_next = bit_reg + 6'h1;
          half_next = half_len;
        end
      end
      default:
      begin
        state_next = SER_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      state_reg <= SER_IDLE;
      shift_reg <= '0;
      bit_reg <= 6'h0;
      half_reg <= 11'h0;
      phase_reg <= 1'b0;
      a_reg <= 1'b0;
      b_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      half_reg <= half_next;
      phase_reg <= phase_next;
      a_reg <= a_next;
      b_reg <= b_next;
    end
  end

  assign line_a_o = a_reg;
  assign line_b_o = b_reg;
  assign busy_o = (state_reg != SER_IDLE);
endmodule
`default_nettype wire

// ==== design/arinc_tx_frame_scheduler.sv ====
// transmit scheduler: table, frame clocks, scan and output
`timescale 1ns/1ps
`default_nettype none
`include "arinc_sched_defines.svh"
// Overview of operation
// - table holds 256 control plus word entries
// - sixteen independent minor frame clocks
// - each minor clock has offset and period
// - major tick restarts every minor clock
// - major starts table, minors time entries
// - periodic entry sent in each of its frames, once-only entry in its first only
// - runs on its own once started
// - start sends words in table order
// - word updates accepted while running
// - plain mode: master, periodic, microsecond delay
// - bit rate low or high speed
// - mask bit n selects minor frame n
// - minors in 100 us, major by prescaler
// - two data pages, swap at boundary
module arinc_tx_frame_scheduler
(
  input  wire logic                           ref_clk_i,
  input  wire logic                           reset_i,
  input  wire logic                           sched_enable_i,
  input  wire logic                           major_minor_frame_mode_i,
  input  wire logic                           high_speed_i,
  input  wire logic [`SCHED_PRESCALE_W-1:0]   user_frame_prescaler_i,
  input  wire logic [`SCHED_CNT_W-1:0]        major_count_i,
  input  wire logic [`SCHED_IDX_W:0]          entry_count_i,
  input  wire logic                           ctl_write_i,
  input  wire logic                           data_write_i,
  input  wire logic [`SCHED_IDX_W-1:0]        entry_index_i,
  input  wire logic                           entry_enable_i,
  input  wire logic                           entry_periodic_i,
  input  wire logic                           entry_master_i,
  input  wire logic [`SCHED_DELAY_W-1:0]      entry_delay_i,
  input  wire logic [`SCHED_MINOR_FRAMES-1:0] minor_frame_select_mask_i,
  input  wire logic [`SCHED_WORD_W-1:0]       entry_word_i,
  input  wire logic                           write_page_i,
  input  wire logic                           swap_request_i,
  input  wire logic                           swap_at_major_i,
  input  wire logic                           minor_write_i,
  input  wire logic [3:0]                     minor_index_i,
  input  wire logic [`SCHED_CNT_W-1:0]        minor_offset_i,
  input  wire logic [`SCHED_CNT_W-1:0]        minor_period_i,
  output logic                                line_a_o,
  output logic                                line_b_o,
  output logic                                running_o,
  output logic                                tx_page_o
);
  import arinc_sched_pkg::*;

  // control and two data pages, one word per entry
  logic                           en_mem  [`SCHED_ENTRIES];
  logic                           per_mem [`SCHED_ENTRIES];
  logic                           mst_mem [`SCHED_ENTRIES];
  logic [`SCHED_DELAY_W-1:0]      dly_mem [`SCHED_ENTRIES];
  logic [`SCHED_MINOR_FRAMES-1:0] msk_mem [`SCHED_ENTRIES];
  logic [`SCHED_WORD_W-1:0]       pg0_mem [`SCHED_ENTRIES];
  logic [`SCHED_WORD_W-1:0]       pg1_mem [`SCHED_ENTRIES];
  logic [`SCHED_ENTRIES-1:0]      sent_reg;
  logic [`SCHED_CNT_W-1:0]        moff_mem [`SCHED_MINOR_FRAMES];
  logic [`SCHED_CNT_W-1:0]        mper_mem [`SCHED_MINOR_FRAMES];

  logic                           run_reg;
  logic                           run_next;
  logic                           start;
  logic                           page_reg;
  logic                           page_next;
  logic                           swap_pend_reg;
  logic                           swap_pend_next;
  logic [`SCHED_CNT_W-1:0]        us_reg;
  logic [`SCHED_CNT_W-1:0]        us_next;
  logic [`SCHED_CNT_W-1:0]        tick_reg;
  logic [`SCHED_CNT_W-1:0]        tick_next;
  logic [`SCHED_CNT_W-1:0]        major_reg;
  logic [`SCHED_CNT_W-1:0]        major_next;
  logic                           us_tick;
  logic                           tb_tick;
  logic                           major_tick;
  logic [`SCHED_MINOR_FRAMES-1:0] minor_fire;
  logic [`SCHED_MINOR_FRAMES-1:0] due_reg;
  logic [`SCHED_MINOR_FRAMES-1:0] due_next;
  logic [`SCHED_DELAY_W-1:0]      plain_reg;
  logic [`SCHED_DELAY_W-1:0]      plain_next;
  scan_state_t                    scan_reg;
  scan_state_t                    scan_next;
  logic [`SCHED_IDX_W:0]          idx_reg;
  logic [`SCHED_IDX_W:0]          idx_next;
  logic [`SCHED_MINOR_FRAMES-1:0] hit_reg;
  logic [`SCHED_MINOR_FRAMES-1:0] hit_next;
  logic                           push_valid;
  logic                           push_ready;
  logic [`SCHED_WORD_W-1:0]       push_word;
  logic [`SCHED_IDX_W-1:0]        cur;
  logic                           buf_valid;
  logic                           buf_ready;
  logic [`SCHED_WORD_W-1:0]       buf_word;
  logic                           ser_a;
  logic                           ser_b;
  logic                           a_reg;
  logic                           b_reg;
  logic                           rnr_reg;
  logic                           pgo_reg;

  // table writes: words at any time, control only while stopped
  always_ff @(posedge ref_clk_i)
  begin
    if (ctl_write_i && !run_reg)
    begin
      en_mem[entry_index_i] <= entry_enable_i;
      per_mem[entry_index_i] <= entry_periodic_i;
      mst_mem[entry_index_i] <= entry_master_i;
      dly_mem[entry_index_i] <= entry_delay_i;
      msk_mem[entry_index_i] <= minor_frame_select_mask_i;
    end
    if (data_write_i && !write_page_i)
    begin
      pg0_mem[entry_index_i] <= entry_word_i;
    end
    if (data_write_i && write_page_i)
    begin
      pg1_mem[entry_index_i] <= entry_word_i;
    end
    if (minor_write_i && !run_reg)
    begin
      moff_mem[minor_index_i] <= minor_offset_i;
      mper_mem[minor_index_i] <= minor_period_i;
    end
  end

  // run control, timebases, major frame and page swap
  always_comb
  begin
    run_next = sched_enable_i;
    start = sched_enable_i && !run_reg;
    us_tick = (us_reg == `SCHED_CNT_W'(`SCHED_US_CYC - 1));
    tb_tick = (tick_reg == `SCHED_CNT_W'(`SCHED_TICK_CYC - 1));
    us_next = (us_tick || !run_reg) ? '0 : us_reg + 1'b1;
    tick_next = (tb_tick || !run_reg) ? '0 : tick_reg + 1'b1;
    // major period = prescaler (in 100 us ticks) times count
    major_next = major_reg;
    major_tick = 1'b0;
    if (start)
    begin
      major_next = '0;
      major_tick = major_minor_frame_mode_i;
    end
    else if (run_reg && tb_tick)
    begin
      if (major_reg >= `SCHED_CNT_W'(user_frame_prescaler_i * major_count_i) - 1'b1)
      begin
        major_next = '0;
        major_tick = major_minor_frame_mode_i;
      end
      else
      begin
        major_next = major_reg + 1'b1;
      end
    end
    page_next = page_reg;
    swap_pend_next = swap_pend_reg || swap_request_i;
    if (swap_pend_reg && (!swap_at_major_i || major_tick))
    begin
      page_next = ~page_reg;
      swap_pend_next = swap_request_i;
    end
  end

  // minor clocks: fire at offset then each period, realigned by major
  genvar g;
  generate
    for (g = 0; g < `SCHED_MINOR_FRAMES; g = g + 1)
    begin : g_minor
      logic [`SCHED_CNT_W-1:0] cnt_reg;
      logic [`SCHED_CNT_W-1:0] cnt_next;
      logic                    armed_reg;
      logic                    armed_next;
      always_comb
      begin
        cnt_next = cnt_reg;
        armed_next = armed_reg;
        minor_fire[g] = 1'b0;
        if (major_tick)
        begin
          cnt_next = moff_mem[g];
          armed_next = 1'b1;
          minor_fire[g] = (moff_mem[g] == '0);
          if (minor_fire[g])
          begin
            cnt_next = mper_mem[g];
            armed_next = (mper_mem[g] != '0); // period 0: once per major
          end
        end
        else if (armed_reg && tb_tick)
        begin
          if (cnt_reg <= `SCHED_CNT_W'(1))
          begin
            minor_fire[g] = 1'b1;
            cnt_next = mper_mem[g];
            armed_next = (mper_mem[g] != '0);
          end
          else
          begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        if (!run_reg && !start) // start is itself a major tick in frame mode
        begin
          armed_next = 1'b0;
        end
      end
      always_ff @(posedge ref_clk_i)
      begin
        if (reset_i)
        begin
          cnt_reg <= '0;
          armed_reg <= 1'b0;
        end
        else
        begin
          cnt_reg <= cnt_next;
          armed_reg <= armed_next;
        end
      end
    end
  endgenerate

  // table scan: one pass per batch of merged due frames, ascending index
  always_comb
  begin
    cur = idx_reg[`SCHED_IDX_W-1:0];
    scan_next = scan_reg;
    idx_next = idx_reg;
    hit_next = hit_reg;
    due_next = due_reg | minor_fire; // late frames merge, none lost
    plain_next = plain_reg;
    push_valid = 1'b0;
    push_word = page_reg ? pg1_mem[cur] : pg0_mem[cur];
    if (run_reg && us_tick && plain_reg != '0)
    begin
      plain_next = plain_reg - 1'b1;
    end
    case (scan_reg)
      SCAN_IDLE:
      begin
        if (start)
        begin
          idx_next = '0;
          hit_next = '1;
          scan_next = major_minor_frame_mode_i ? SCAN_WAIT : SCAN_CHECK;
        end
      end
      SCAN_WAIT:
      begin
        if (due_reg != '0 && major_minor_frame_mode_i)
        begin
          hit_next = due_reg;
          due_next = minor_fire;
          idx_next = '0;
          scan_next = SCAN_CHECK;
        end
        else if (!major_minor_frame_mode_i && plain_reg == '0)
        begin
          idx_next = '0;
          hit_next = '1;
          scan_next = SCAN_CHECK;
        end
      end
      SCAN_CHECK:
      begin
        if (idx_reg >= entry_count_i)
        begin
          scan_next = SCAN_WAIT;
        end
        else if (en_mem[cur] && !sent_reg[cur] &&
                 (major_minor_frame_mode_i ? ((msk_mem[cur] & hit_reg) != '0) : 1'b1))
        begin
          scan_next = SCAN_PUSH;
        end
        else
        begin
          idx_next = idx_reg + 1'b1;
        end
      end
      SCAN_PUSH:
      begin
        push_valid = 1'b1;
        if (push_ready)
        begin
          idx_next = idx_reg + 1'b1;
          scan_next = SCAN_CHECK;
          if (!major_minor_frame_mode_i && (mst_mem[cur] || plain_reg == '0))
          begin
            plain_next = dly_mem[cur];
          end
          if (!major_minor_frame_mode_i && mst_mem[cur])
          begin
            scan_next = SCAN_WAIT;
          end
        end
      end
      default:
      begin
        scan_next = SCAN_IDLE;
      end
    endcase
    if (!run_reg && !start) // keep the start step and its due frames
    begin
      scan_next = SCAN_IDLE;
      due_next = '0;
      plain_next = '0;
    end
  end

  // once-only entries marked on their first push, cleared by start
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || start)
    begin
      sent_reg <= '0;
    end
    else if (scan_reg == SCAN_PUSH && push_ready && !per_mem[cur])
    begin
      sent_reg[cur] <= 1'b1;
    end
  end

  // state registers and registered outputs
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      run_reg <= 1'b0;
      page_reg <= 1'b0;
      swap_pend_reg <= 1'b0;
      us_reg <= '0;
      tick_reg <= '0;
      major_reg <= '0;
      scan_reg <= SCAN_IDLE;
      idx_reg <= '0;
      hit_reg <= '0;
      due_reg <= '0;
      plain_reg <= '0;
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      rnr_reg <= 1'b0;
      pgo_reg <= 1'b0;
    end
    else
    begin
      run_reg <= run_next;
      page_reg <= page_next;
      swap_pend_reg <= swap_pend_next;
      us_reg <= us_next;
      tick_reg <= tick_next;
      major_reg <= major_next;
      scan_reg <= scan_next;
      idx_reg <= idx_next;
      hit_reg <= hit_next;
      due_reg <= due_next;
      plain_reg <= plain_next;
      a_reg <= ser_a;
      b_reg <= ser_b;
      rnr_reg <= run_reg;
      pgo_reg <= page_reg;
    end
  end

  word_skid_buffer u_buf
  (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_word),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready),
    .out_data_o  (buf_word)
  );

  arinc_serializer u_ser
  (
    .ref_clk_i    (ref_clk_i),
    .reset_i      (reset_i),
    .high_speed_i (high_speed_i),
    .word_valid_i (buf_valid),
    .word_ready_o (buf_ready),
    .word_i       (buf_word),
    .line_a_o     (ser_a),
    .line_b_o     (ser_b),
    .busy_o       ()
  );

  assign line_a_o = a_reg;
  assign line_b_o = b_reg;
  assign running_o = rnr_reg;
  assign tx_page_o = pgo_reg;
endmodule
`default_nettype wire

// ==== verification/line_rx_model.sv ====
// line receiver model that rebuilds words from the bipolar pair
`timescale 1ns/1ps
`default_nettype none
module line_rx_model
(
  input  wire logic   ref_clk_i,
  input  wire logic   line_a_i,
  input  wire logic   line_b_i,
  output logic [31:0] word_o,
  output logic        word_valid_o
);
  logic [1:0] prev_reg = 2'h0;
  logic [4:0] nbit_reg = 5'h0;
  // a bit starts where the pair leaves null; lsb first, so shift in at the top
  always @(posedge ref_clk_i)
  begin
    prev_reg <= {line_a_i, line_b_i};
    word_valid_o <= 1'b0;
    if (prev_reg == 2'h0 && {line_a_i, line_b_i} != 2'h0)
    begin
      word_o <= {line_a_i, word_o[31:1]};
      nbit_reg <= nbit_reg + 5'h1;
      word_valid_o <= (nbit_reg == 5'h1F);
    end
  end
endmodule
`default_nettype wire

// ==== verification/sched_port_properties.sv ====
// port assertions for the transmit frame scheduler
`timescale 1ns/1ps
`default_nettype none
`include "arinc_sched_defines.svh"
module sched_port_checker
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic sched_enable_i,
  input wire logic high_speed_i,
  input wire logic swap_request_i,
  input wire logic swap_at_major_i,
  input wire logic line_a_o,
  input wire logic line_b_o,
  input wire logic running_o,
  input wire logic tx_page_o
);
  logic [1:0]  lines;
  logic [1:0]  lines_reg;
  logic [15:0] hold_reg;
  logic        page_reg;
  int          half;
  assign lines = {line_a_o, line_b_o};
  assign half = high_speed_i ? `SCHED_HI_HALF_CYC : `SCHED_LO_HALF_CYC;
  // age of the line level; saturates so a long idle never looks short
  always_ff @(posedge ref_clk_i)
  begin
    lines_reg <= reset_i ? 2'h0 : lines;
    if (reset_i)
      hold_reg <= 16'hFFFF;
    else if (lines != lines_reg)
      hold_reg <= 16'h1;
    else if (hold_reg != 16'hFFFF)
      hold_reg <= hold_reg + 16'h1;
    if (swap_request_i)
      page_reg <= tx_page_o;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_start;
    $rose(sched_enable_i) ##1 sched_enable_i;
  endsequence
  sequence s_level_end;
    lines_reg != 2'h0 && lines != lines_reg;
  endsequence
  property p_gap;
    lines_reg == 2'h0 && lines != 2'h0 |-> int'(hold_reg) == half || int'(hold_reg) >= 8 * half;
  endproperty
  property p_swap;
    swap_request_i && !swap_at_major_i |-> ##[1:4] tx_page_o != page_reg;
  endproperty
  a_no_overlap: assert property (!(line_a_o && line_b_o))
    else $error("both lines high");
  a_half_bit: assert property (s_level_end |-> int'(hold_reg) == half)
    else $error("half bit length off");
  a_word_gap: assert property (p_gap)
    else $error("null before bit too short");
  a_run_rise: assert property (s_start |-> ##1 running_o)
    else $error("running late after enable");
  a_run_fall: assert property ($fell(sched_enable_i) |-> ##2 !running_o)
    else $error("running stuck after disable");
  a_run_cause: assert property (running_o |-> $past(sched_enable_i, 2))
    else $error("running without enable");
  a_reset_idle: assert property ($fell(reset_i) |-> !running_o && lines == 2'h0)
    else $error("outputs busy after reset");
  a_page_swap: assert property (p_swap)
    else $error("page did not swap");
endmodule
bind arinc_tx_frame_scheduler sched_port_checker u_sched_port_checker
(
  .ref_clk_i, .reset_i, .sched_enable_i, .high_speed_i, .swap_request_i,
  .swap_at_major_i, .line_a_o, .line_b_o, .running_o, .tx_page_o
);
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the transmit frame scheduler
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        sched_enable_i = 1'b0;
  logic        fmode = 1'b0;
  logic        swap = 1'b0;
  logic        cwr = 1'b0;
  logic        dwr = 1'b0;
  logic        mwr = 1'b0;
  logic        en = 1'b0;
  logic        per = 1'b0;
  logic        wpg = 1'b0;
  logic [3:0]  midx = 4'h0;
  logic [7:0]  idx = 8'h0;
  logic [8:0]  cnt = 9'h0;
  logic [15:0] pre = 16'h0;
  logic [15:0] mask = 16'h0;
  logic [15:0] moff = 16'h0;
  logic [15:0] mper = 16'h0;
  logic [31:0] word = 32'h0;
  logic [31:0] rx_word;
  logic        rx_valid;
  logic        la;
  logic        lb;
  logic        run;
  logic        page;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  arinc_tx_frame_scheduler u_arinc_tx_frame_scheduler
  (
    .ref_clk_i, .reset_i, .sched_enable_i, .major_minor_frame_mode_i(fmode),
    .high_speed_i(1'b1), .user_frame_prescaler_i(pre), .major_count_i(16'h1),
    .entry_count_i(cnt), .ctl_write_i(cwr), .data_write_i(dwr), .entry_index_i(idx),
    .entry_enable_i(en), .entry_periodic_i(per), .entry_master_i(1'b0),
    .entry_delay_i(24'h0), .minor_frame_select_mask_i(mask), .entry_word_i(word),
    .write_page_i(wpg), .swap_request_i(swap), .swap_at_major_i(1'b0),
    .minor_write_i(mwr), .minor_index_i(midx), .minor_offset_i(moff),
    .minor_period_i(mper), .line_a_o(la), .line_b_o(lb), .running_o(run), .tx_page_o(page)
  );
  line_rx_model u_line_rx_model
  (
    .ref_clk_i, .line_a_i(la), .line_b_i(lb), .word_o(rx_word), .word_valid_o(rx_valid)
  );
  // clock, and a cycle ceiling so a hang still reaches the report
  initial
    forever #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 98000)
    begin
      err_total++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // table and minor clock writes: one strobe cycle each
  task automatic put_ctl(input logic [7:0] i, input logic e, input logic p, input logic [15:0] m);
    tick(1);
    {idx, en, per, mask, cwr} = {i, e, p, m, 1'b1};
    tick(1);
    cwr = 1'b0;
  endtask
  task automatic put_dat(input logic [7:0] i, input logic [31:0] w, input logic pg);
    tick(1);
    {idx, word, wpg, dwr} = {i, w, pg, 1'b1};
    tick(1);
    dwr = 1'b0;
  endtask
  task automatic put_min(input logic [3:0] i, input logic [15:0] o, input logic [15:0] p);
    tick(1);
    {midx, moff, mper, mwr} = {i, o, p, 1'b1};
    tick(1);
    mwr = 1'b0;
  endtask
  // waits a bounded time for the next whole word at the receiver
  task automatic rx_chk(input logic [31:0] exp);
    int n = 0;
    while (rx_valid !== 1'b1 && n < 20000)
    begin
      tick(1);
      n++;
    end
    chk("rx word", exp, (n < 20000) ? rx_word : ~exp);
    tick(1);
  endtask
  // junk goes to page 1, then the transmit page is flipped there and back
  task automatic test_page();
    put_dat(8'h1, 32'hDEAD0001, 1'b1);
    for (int k = 1; k >= 0; k--)
    begin
      tick(1);
      swap = 1'b1;
      tick(1);
      swap = 1'b0;
      tick(4);
      chk("tx page", k, {31'h0, page});
    end
  endtask
  // minor 0 at start, minor 1 one tick later; entry 1 sits in both
  task automatic test_frame();
    fmode = 1'b1;
    cnt = 9'h3;
    pre = 16'h64;
    put_min(4'h0, 16'h0, 16'h0);
    put_min(4'h1, 16'h1, 16'h64);
    put_ctl(8'h0, 1'b1, 1'b1, 16'h0002);
    put_ctl(8'h1, 1'b1, 1'b1, 16'h0003);
    put_ctl(8'h2, 1'b1, 1'b0, 16'h0001);
    put_dat(8'h0, 32'h11110000, 1'b0);
    put_dat(8'h1, 32'h22220001, 1'b0);
    put_dat(8'h2, 32'h33330002, 1'b0);
    tick(1);
    sched_enable_i = 1'b1;
    tick(100);
    chk("running", 32'h1, {31'h0, run});
    put_dat(8'h0, 32'h4444AAAA, 1'b0);
    put_ctl(8'h1, 1'b0, 1'b0, 16'h0);
    rx_chk(32'h22220001);
    rx_chk(32'h33330002);
    rx_chk(32'h4444AAAA);
    rx_chk(32'h22220001);
    tick(2000);
    sched_enable_i = 1'b0;
  endtask
  // plain mode, two one-shot entries, then the line must stay idle
  task automatic test_plain();
    int busy = 0;
    tick(4);
    chk("running", 32'h0, {31'h0, run});
    fmode = 1'b0;
    cnt = 9'h2;
    put_ctl(8'h0, 1'b1, 1'b0, 16'h0);
    put_ctl(8'h1, 1'b1, 1'b0, 16'h0);
    tick(1);
    sched_enable_i = 1'b1;
    rx_chk(32'h4444AAAA);
    rx_chk(32'h22220001);
    tick(600);
    repeat (3000)
    begin
      tick(1);
      if ((la | lb) !== 1'b0)
        busy++;
    end
    chk("idle cycles", 32'h0, busy);
    sched_enable_i = 1'b0;
  endtask
  initial
  begin
    tick(5);
    reset_i = 1'b0;
    test_page();
    test_frame();
    test_plain();
    results();
  end
endmodule
`default_nettype wire
